/* File: rtl/pps_priority_shutdown.sv */
// Priority shutdown control for an eight-port power sourcing controller.
`timescale 1ns/1ps
`include "pps_defines.svh"

module pps_priority_shutdown #(
    parameter int NUM_PORTS = 8,
    parameter int MIN_LOW   = `PPS_MIN_LOW_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  clkEn,
    input  wire logic                  priorityCutInput_n,
    input  wire pps_pkg::pps_bus_req_s busReq,
    output logic [7:0]                 rdData,
    output logic [NUM_PORTS-1:0]       portPowerOn,
    output logic [NUM_PORTS-1:0]       portDetectEn,
    output logic [NUM_PORTS-1:0]       portClassEn,
    output logic                       shutdownActive
);
    import pps_pkg::*;

    // ****************************************************************
    // Derived constants
    // ****************************************************************
    // The counter saturates at MIN_LOW, so it needs room for that value itself.
    localparam int            CW       = $clog2(MIN_LOW + 1);
    localparam logic [CW-1:0] LOW_TOP  = CW'(MIN_LOW);
    localparam logic [CW-1:0] LOW_LAST = CW'(MIN_LOW - 1);

    // ****************************************************************
    // Input synchroniser and low-pulse qualifier
    // ****************************************************************
    logic          syncA_reg;
    logic          syncB_reg;
    logic [CW-1:0] lowCnt_reg;
    pps_state_e    state_reg;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Parked at the idle level, so leaving reset never looks like a falling input.
            syncA_reg <= 1'b1;
            syncB_reg <= 1'b1;
        end
        else if (clkEn)
        begin
            syncA_reg <= priorityCutInput_n;
            syncB_reg <= syncA_reg;
        end
    end

    // A glitch shorter than the minimum width restarts the count, so noise never cuts power.
    // Only enabled edges count, so a slow clock enable stretches the qualifying time.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            lowCnt_reg <= '0;
        else if (clkEn)
        begin
            if (syncB_reg)
                lowCnt_reg <= '0;
            else if (lowCnt_reg != LOW_TOP)
                lowCnt_reg <= lowCnt_reg + CW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            state_reg <= PPS_IDLE;
        else if (clkEn)
        begin
            unique case (state_reg)
                PPS_IDLE:
                begin
                    if (!syncB_reg && (lowCnt_reg == LOW_LAST))
                        state_reg <= PPS_SHUT;
                end
                PPS_SHUT:
                begin
                    if (syncB_reg)
                        state_reg <= PPS_IDLE;
                end
                default:
                begin
                    state_reg <= PPS_IDLE;
                end
            endcase
        end
    end

    logic shutNow;
    assign shutNow = (state_reg == PPS_SHUT);
    // Status is decoded from the state flops only, so input noise never reaches it.
    assign shutdownActive = shutNow;

    // ****************************************************************
    // Per-port configuration and power state
    // ****************************************************************
    logic [7:0]           conf_reg [NUM_PORTS];
    logic [NUM_PORTS-1:0] power_reg;
    logic [NUM_PORTS-1:0] lowPrio;

    function automatic logic confHit(input logic [3:0] a, input int p);
        confHit = (a == (`PPS_OFF_CONF_BASE + 4'(p)));
    endfunction : confHit

    // ****************************************************************
    // Bus request decode
    // ****************************************************************
    logic                 wrPowerCmd;
    logic                 rdPowerAny;
    logic                 rdShutStat;
    logic [NUM_PORTS-1:0] wrConf;
    logic [NUM_PORTS-1:0] rdConf;

    assign wrPowerCmd = busReq.wr && (busReq.addr == `PPS_OFF_POWER_CMD);
    assign rdShutStat = busReq.rd && (busReq.addr == `PPS_OFF_SHUT_STAT);
    // Both power offsets return the live state; a masked command is never read back.
    assign rdPowerAny = busReq.rd
                        && ((busReq.addr == `PPS_OFF_POWER_CMD)
                            || (busReq.addr == `PPS_OFF_POWER_STAT));

    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++)
        begin : gPort
            assign lowPrio[g]      = conf_reg[g][`PPS_BIT_PRIORITY];
            assign portDetectEn[g] = conf_reg[g][`PPS_BIT_DETENA];
            assign portClassEn[g]  = conf_reg[g][`PPS_BIT_CLASSENA];

            assign wrConf[g] = busReq.wr && confHit(busReq.addr, g);
            assign rdConf[g] = busReq.rd && confHit(busReq.addr, g);

            // Each port owns its byte, so a write to one port never disturbs another.
            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                    conf_reg[g] <= `PPS_CONF_RESET;
                else if (clkEn)
                begin
                    if (wrConf[g])
                        conf_reg[g] <= busReq.wdata;
                    if (shutNow)
                    begin
                        conf_reg[g][`PPS_BIT_DETENA]   <= 1'b0;
                        conf_reg[g][`PPS_BIT_CLASSENA] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    logic [NUM_PORTS-1:0] powerWrite;
    assign powerWrite = wrPowerCmd ? busReq.wdata[NUM_PORTS-1:0] : power_reg;

    // Masking only ever clears bits, but a power command write still switches on any port that is not low priority.
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            power_reg <= '0;
        else if (clkEn)
        begin
            if (shutNow)
                power_reg <= powerWrite & ~lowPrio;
            else
                power_reg <= powerWrite;
        end
    end
    assign portPowerOn = power_reg;

    // ****************************************************************
    // Register read port
    // ****************************************************************
    logic [7:0] readMux;

    // Idle cycles with clkEn high return zero, so a late sample shows stale register contents only while clkEn is low.
    always_comb
    begin
        readMux = 8'h00;
        if (rdPowerAny)
            readMux = 8'(power_reg);
        else if (rdShutStat)
            readMux = {7'h00, shutNow};
        else
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                if (rdConf[i])
                    readMux = conf_reg[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdData <= 8'h00;
        else if (clkEn)
            rdData <= readMux;
    end

endmodule : pps_priority_shutdown

/* File: rtl/pps_defines.svh */
// Offsets, field positions, reset values and timing counts for the priority shutdown block.
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PPS_ADDR_W         4
`define PPS_OFF_CONF_BASE  4'h0
`define PPS_OFF_POWER_CMD  4'h8
`define PPS_OFF_POWER_STAT 4'h9
`define PPS_OFF_SHUT_STAT  4'ha

// ****************************************************************
// Configuration byte fields
// ****************************************************************
`define PPS_BIT_DETENA     2
`define PPS_BIT_CLASSENA   3
`define PPS_BIT_PRIORITY   4
`define PPS_CONF_RESET     8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define PPS_CLK_HZ         25000000
`define PPS_MIN_LOW_NS     5000
`define PPS_MIN_LOW_CYC    ((`PPS_MIN_LOW_NS * (`PPS_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* File: rtl/pps_pkg.sv */
// Types shared by the priority shutdown block.
package pps_pkg;

    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pps_bus_req_s;

    typedef enum logic [1:0]
    {
        PPS_IDLE = 2'b01,
        PPS_SHUT = 2'b10
    } pps_state_e;

endpackage : pps_pkg

/* File: dv/pps_shutdown_props.sv */
// Port assertions for the priority shutdown block.
`timescale 1ns/1ps
module pps_shutdown_props #(
    parameter int MIN_LOW = 125
) (
    input wire logic                  ref_clk,
    input wire logic                  reset_n,
    input wire logic                  priorityCutInput_n,
    input wire pps_pkg::pps_bus_req_s busReq,
    input wire logic [7:0]            rdData,
    input wire logic [7:0]            portPowerOn,
    input wire logic [7:0]            portDetectEn,
    input wire logic [7:0]            portClassEn,
    input wire logic                  shutdownActive
);
    import pps_pkg::*;
    logic [15:0] lowCnt_reg;
    // Counts raw low samples, so the sync lag only adds margin.
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n) lowCnt_reg <= 16'h0000;
        else if (priorityCutInput_n) lowCnt_reg <= 16'h0000;
        else if (lowCnt_reg != 16'hffff) lowCnt_reg <= lowCnt_reg + 16'h0001;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_NO_NEW_POWER: assert property (shutdownActive && !busReq.wr
        |=> (portPowerOn & ~$past(portPowerOn)) == 8'h00) else $error("power rose");
    AST_ENABLES_CLEARED: assert property (shutdownActive [*2]
        |-> portDetectEn == 8'h00 && portClassEn == 8'h00) else $error("enables kept");
    AST_QUALIFY: assert property ($rose(shutdownActive)
        |-> lowCnt_reg >= MIN_LOW) else $error("early shutdown");
    AST_RELEASE: assert property ($rose(priorityCutInput_n)
        |-> ##[1:5] !shutdownActive) else $error("no release");
    AST_HOLD: assert property (shutdownActive && !priorityCutInput_n
        && !$past(priorityCutInput_n, 2)
        |=> shutdownActive) else $error("shutdown dropped");
    AST_STATUS_READ: assert property (busReq.rd && busReq.addr == 4'ha
        |=> rdData == {7'h00, $past(shutdownActive)}) else $error("bad status");
    AST_ENABLE_HOLD: assert property (!shutdownActive && !busReq.wr
        |=> $stable(portDetectEn) && $stable(portClassEn)) else $error("enables moved");
    AST_POWER_HOLD: assert property (!shutdownActive && !busReq.wr
        |=> $stable(portPowerOn)) else $error("power moved");
    cover property ($rose(shutdownActive));
    cover property (busReq.wr && shutdownActive);
    cover property ($fell(shutdownActive));
endmodule : pps_shutdown_props

/* File: dv/pps_cut_source.sv */
// Shutdown source that holds the cut input low for a commanded count.
`timescale 1ns/1ps
module pps_cut_source (
    input  wire logic       ref_clk,
    input  wire logic       fire,
    input  wire logic [7:0] len,
    output logic            cutN
);
    logic [7:0] left_reg = 8'h00;
    // The line is pulled up, so an idle source reads high.
    assign cutN = (left_reg == 8'h00);
    always @(posedge ref_clk)
        if (fire) left_reg <= len;
        else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
endmodule : pps_cut_source

/* File: dv/pps_priority_shutdown_test.sv */
// Self-checking bench for the priority shutdown block.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected %0t got %h exp %h", $time, a, e); end end
module pps_priority_shutdown_test;
    import pps_pkg::*;
    localparam int ML = 8;
    logic         ref_clk = 1'h0, reset_n = 1'h0, fire = 1'h0, clkEn = 1'h1, act, cutN;
    logic [7:0]   len = 8'h00, rdData, pow, det, cls;
    pps_bus_req_s busReq = '0;
    int           n_mismatch = 0, check_count = 0, cyc = 0;
    always #20 ref_clk = ~ref_clk;
    pps_cut_source u_pps_cut_source (.ref_clk(ref_clk), .fire(fire), .len(len), .cutN(cutN));
    pps_priority_shutdown #(.MIN_LOW(ML)) u_pps_priority_shutdown (.ref_clk(ref_clk),
        .reset_n(reset_n), .clkEn(clkEn), .priorityCutInput_n(cutN), .busReq(busReq),
        .rdData(rdData), .portPowerOn(pow), .portDetectEn(det), .portClassEn(cls),
        .shutdownActive(act));
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        busReq <= '{a, d, 1'h1, 1'h0};
        @(posedge ref_clk);
        busReq <= '0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        busReq <= '{a, 8'h00, 1'h0, 1'h1};
        @(posedge ref_clk);
        busReq <= '0;
        #1 `CHK(rdData, e)
        @(posedge ref_clk);
    endtask : rd
    task automatic pulse(input logic [7:0] n);
        len <= n;
        fire <= 1'h1;
        @(posedge ref_clk);
        fire <= 1'h0;
    endtask : pulse
    task automatic t_cut;
        for (int p = 0; p < 8; p++) wr(p[3:0], p[0] ? 8'h1c : 8'h0c);
        wr(4'h8, 8'h0f);
        pulse(8'h28);
        repeat (ML + 6) @(posedge ref_clk);
        `CHK({act, pow, det, cls}, {1'h1, 8'h05, 8'h00, 8'h00})
        wr(4'h8, 8'hff);
        `CHK(pow, 8'h55)
        rd(4'ha, 8'h01);
        wr(4'h1, 8'h1c);
        `CHK(det, 8'h00)
        repeat (30) @(posedge ref_clk);
        `CHK({act, pow}, {1'h0, 8'h55})
        rd(4'h9, 8'h55);
        rd(4'h1, 8'h10);
        rd(4'h0, 8'h00);
        wr(4'h1, 8'h1c);
        `CHK({det, cls}, {8'h02, 8'h02})
    endtask : t_cut
    task automatic t_short;
        wr(4'h8, 8'hff);
        pulse(8'h04);
        repeat (ML + 8) @(posedge ref_clk);
        `CHK({act, pow}, {1'h0, 8'hff})
        rd(4'h8, 8'hff);
        rd(4'hf, 8'h00);
    endtask : t_short
    task automatic t_hold;
        clkEn <= 1'h0;
        pulse(8'h28);
        wr(4'h8, 8'h00);
        repeat (ML + 40) @(posedge ref_clk);
        `CHK({act, pow}, {1'h0, 8'hff})
        clkEn <= 1'h1;
        @(posedge ref_clk);
    endtask : t_hold
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    always @(posedge ref_clk) if (++cyc > 3000) begin n_mismatch++; tally_and_finish(); end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'h1;
        @(posedge ref_clk);
        t_cut();
        t_short();
        t_hold();
        tally_and_finish();
    end
endmodule : pps_priority_shutdown_test
bind pps_priority_shutdown pps_shutdown_props #(.MIN_LOW(MIN_LOW)) u_pps_shutdown_props (
    .ref_clk(ref_clk), .reset_n(reset_n), .priorityCutInput_n(priorityCutInput_n),
    .busReq(busReq), .rdData(rdData), .portPowerOn(portPowerOn),
    .portDetectEn(portDetectEn), .portClassEn(portClassEn), .shutdownActive(shutdownActive));
